// [dcx_pkg.sv]
// dcx_pkg: register map, field layout and timing of the chained dma channel
package dcx_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BTGT = 8'h04;
  localparam logic [7:0] OFS_BREQ = 8'h08;
  localparam logic [7:0] OFS_BCNT = 8'h0C;
  localparam logic [7:0] OFS_CTGT = 8'h10;
  localparam logic [7:0] OFS_CREQ = 8'h14;
  localparam logic [7:0] OFS_CCNT = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;

  // ****************************************
  // control fields and reset values
  // ****************************************
  localparam int CTL_XFER_LSB = 0;
  localparam int CTL_PROC_LSB = 2;
  localparam int CTL_SRC_BIT  = 4;
  localparam int CTL_CHAN_LSB = 5;
  localparam int CTL_EN_BIT   = 8;
  localparam int BTGT_MSB_LANE = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] BASE_RST = 32'h0000_0000;

  // ****************************************
  // status fields
  // ****************************************
  localparam int STA_BUSY_BIT = 0;
  localparam int STA_FULL_BIT = 1;
  localparam int STA_OOB_BIT  = 2;
  localparam int STA_IRQ_BIT  = 3;
  localparam int STA_STOP_BIT = 4;

  // ****************************************
  // mode codes
  // ****************************************
  localparam logic [1:0] XFER_SINGLE = 2'h0;
  localparam logic [1:0] XFER_BLOCK  = 2'h1;
  localparam logic [1:0] XFER_DEMAND = 2'h2;
  localparam logic [1:0] PROC_SINGLE = 2'h0;
  localparam logic [1:0] PROC_AUTO   = 2'h1;
  localparam logic [1:0] PROC_CHAIN  = 2'h2;
  localparam logic [2:0] ACK_IDLE    = 3'h4;

  // ****************************************
  // latencies in bus states (one clock each)
  // ****************************************
  localparam logic [2:0] GRANT_LAT  = 3'h2;
  localparam logic [2:0] RELOAD_LAT = 3'h7;
  localparam logic [2:0] SRC_IDLE   = 3'h2;

endpackage : dcx_pkg

// [dcx_chain_xfer.sv]
// dcx_chain_xfer: one dma channel with buffer processes and handshake modes
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module dcx_chain_xfer (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // host bus handshake
  output logic             bus_hold_req_out,
  input  wire logic        bus_hold_grant_in,
  // requesting peripheral
  input  wire logic        channel_request_line_in,
  input  wire logic        end_of_process_line_n_in,
  output logic             end_of_process_line_n_out,
  output logic             end_of_process_line_oe_out,
  output logic      [2:0]  encoded_channel_ack_out,
  // bus access strobes
  output logic             acc_req_out,
  output logic             acc_tgt_out,
  output logic      [31:0] acc_addr_out,
  // chain reload interrupt request
  output logic             chain_reload_irq_out
);

  // ****************************************
  // types and signals
  // ****************************************
  typedef enum logic [2:0] {
    S_IDLE, S_HOLD, S_LAT, S_REQ, S_TGT, S_RLD, S_SIDL, S_REL
  } dcx_state_t;

  dcx_state_t  st_q;
  dcx_state_t  st_d;
  dcx_state_t  rel_st;
  logic [2:0]  sc_q;
  logic [2:0]  sc_d;
  logic [2:0]  rel_sc;
  logic [31:0] ctrl_q;
  logic [31:0] base_tgt_q;
  logic [31:0] base_req_q;
  logic [31:0] base_cnt_q;
  logic [31:0] cur_tgt_q;
  logic [31:0] cur_req_q;
  logic [31:0] cur_cnt_q;
  logic        base_full_q;
  logic        irq_q;
  logic        stop_q;
  logic        oob_q;
  logic        eop_seen_q;
  logic        dreq_seen_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        hold_q;
  logic        eop_oe_q;
  logic        eop_n_q;
  logic [2:0]  ack_q;
  logic        acc_req_q;
  logic        acc_tgt_q;
  logic [31:0] acc_addr_q;
  logic [31:0] rd_mux;
  logic        apb_acc;
  logic        apb_wr;
  logic        start;
  logic        wr_msb;
  logic        eop_act;
  logic        buf_done;
  logic        adv;
  logic        cp_chain;
  logic        cp_auto;
  logic        stop_ev;
  logic        oob_ev;
  logic [1:0]  xm;
  logic [1:0]  pm;
  logic        en;
  logic        src;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic reg_hit(input logic [7:0] a);
    logic h;
    h = 1'b0;
    unique case (a)
      dcx_pkg::OFS_CTRL, dcx_pkg::OFS_BTGT, dcx_pkg::OFS_BREQ, dcx_pkg::OFS_BCNT,
      dcx_pkg::OFS_CTGT, dcx_pkg::OFS_CREQ, dcx_pkg::OFS_CCNT, dcx_pkg::OFS_STAT: h = 1'b1;
      default: h = 1'b0;
    endcase
    return h;
  endfunction : reg_hit

  assign xm       = ctrl_q[dcx_pkg::CTL_XFER_LSB +: 2];
  assign pm       = ctrl_q[dcx_pkg::CTL_PROC_LSB +: 2];
  assign en       = ctrl_q[dcx_pkg::CTL_EN_BIT];
  assign src      = ctrl_q[dcx_pkg::CTL_SRC_BIT];
  assign apb_acc  = psel_in & penable_in & pready_q;
  assign apb_wr   = apb_acc & pwrite_in;
  assign wr_msb   = apb_wr & (paddr_in == dcx_pkg::OFS_BTGT)
                  & pstrb_in[dcx_pkg::BTGT_MSB_LANE];
  assign start    = apb_wr & (paddr_in == dcx_pkg::OFS_CTRL) & ~en
                  & pstrb_in[1] & pwdata_in[dcx_pkg::CTL_EN_BIT];
  assign eop_act  = ~eop_oe_q & ~end_of_process_line_n_in;
  assign buf_done = (cur_cnt_q == 32'h0) | eop_seen_q | eop_act;

  // ****************************************
  // apb slave
  // ****************************************
  always_comb begin
    rd_mux = 32'h0;
    unique case (paddr_in)
      dcx_pkg::OFS_CTRL: rd_mux = ctrl_q;
      dcx_pkg::OFS_BTGT: rd_mux = base_tgt_q;
      dcx_pkg::OFS_BREQ: rd_mux = base_req_q;
      dcx_pkg::OFS_BCNT: rd_mux = base_cnt_q;
      dcx_pkg::OFS_CTGT: rd_mux = cur_tgt_q;
      dcx_pkg::OFS_CREQ: rd_mux = cur_req_q;
      dcx_pkg::OFS_CCNT: rd_mux = cur_cnt_q;
      dcx_pkg::OFS_STAT: begin
        rd_mux[dcx_pkg::STA_BUSY_BIT] = hold_q;
        rd_mux[dcx_pkg::STA_FULL_BIT] = base_full_q;
        rd_mux[dcx_pkg::STA_OOB_BIT]  = oob_q;
        rd_mux[dcx_pkg::STA_IRQ_BIT]  = irq_q;
        rd_mux[dcx_pkg::STA_STOP_BIT] = stop_q;
      end
      default: rd_mux = 32'h0;
    endcase
  end

  // one wait state per transfer
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q <= psel_in & penable_in & ~pready_q;
      if (psel_in & penable_in & ~pready_q) begin
        pslverr_q <= ~reg_hit(paddr_in);
        prdata_q  <= pwrite_in ? 32'h0 : rd_mux;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_q     <= dcx_pkg::CTRL_RST;
      base_tgt_q <= dcx_pkg::BASE_RST;
      base_req_q <= dcx_pkg::BASE_RST;
      base_cnt_q <= dcx_pkg::BASE_RST;
    end else if (apb_wr) begin
      unique case (paddr_in)
        dcx_pkg::OFS_CTRL: ctrl_q     <= merge(ctrl_q, pwdata_in, pstrb_in);
        dcx_pkg::OFS_BTGT: base_tgt_q <= merge(base_tgt_q, pwdata_in, pstrb_in);
        dcx_pkg::OFS_BREQ: base_req_q <= merge(base_req_q, pwdata_in, pstrb_in);
        dcx_pkg::OFS_BCNT: base_cnt_q <= merge(base_cnt_q, pwdata_in, pstrb_in);
        default: ;
      endcase
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    rel_st   = src ? S_SIDL : S_REL;
    rel_sc   = dcx_pkg::SRC_IDLE - 3'h1;
    st_d     = st_q;
    sc_d     = sc_q;
    adv      = 1'b0;
    cp_chain = 1'b0;
    cp_auto  = 1'b0;
    stop_ev  = 1'b0;
    oob_ev   = 1'b0;
    unique case (st_q)
      S_IDLE: begin
        if (en & ~stop_q & channel_request_line_in) begin
          st_d = S_HOLD;
        end
      end
      S_HOLD: begin
        if (bus_hold_grant_in) begin
          st_d = S_LAT;
          sc_d = dcx_pkg::GRANT_LAT - 3'h2;
        end
      end
      S_LAT: begin
        if (sc_q == 3'h0) begin
          st_d = S_REQ;
        end else begin
          sc_d = sc_q - 3'h1;
        end
      end
      S_REQ: begin
        if (sc_q == 3'h0) begin
          sc_d = 3'h1;
        end else begin
          st_d = S_TGT;
          sc_d = 3'h0;
        end
      end
      S_TGT: begin
        if (sc_q == 3'h0) begin
          sc_d = 3'h1;
        end else begin
          adv  = 1'b1;
          st_d = rel_st;
          sc_d = rel_sc;
          if (buf_done) begin
            unique case (pm)
              dcx_pkg::PROC_AUTO: begin
                st_d = S_RLD;
                sc_d = dcx_pkg::RELOAD_LAT - 3'h1;
              end
              dcx_pkg::PROC_CHAIN: begin
                if (base_full_q) begin
                  cp_chain = 1'b1;
                end else begin
                  oob_ev  = 1'b1;
                  stop_ev = 1'b1;
                end
              end
              default: stop_ev = 1'b1;
            endcase
          end else if (xm == dcx_pkg::XFER_SINGLE) begin
            st_d = rel_st;
          end else if (xm == dcx_pkg::XFER_DEMAND && !dreq_seen_q) begin
            st_d = rel_st;
          end else begin
            st_d = S_REQ;
            sc_d = 3'h0;
          end
        end
      end
      S_RLD: begin
        if (sc_q == 3'h0) begin
          cp_auto = 1'b1;
          st_d    = rel_st;
          sc_d    = rel_sc;
        end else begin
          sc_d = sc_q - 3'h1;
        end
      end
      S_SIDL: begin
        if (sc_q == 3'h0) begin
          st_d = S_REL;
        end else begin
          sc_d = sc_q - 3'h1;
        end
      end
      S_REL: st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= S_IDLE;
      sc_q <= 3'h0;
    end else begin
      st_q <= st_d;
      sc_q <= sc_d;
    end
  end

  // ****************************************
  // transfer sampling
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      eop_seen_q  <= 1'b0;
      dreq_seen_q <= 1'b0;
    end else begin
      if (adv) begin
        eop_seen_q <= 1'b0;
      end else if ((st_q == S_REQ || st_q == S_TGT) && eop_act) begin
        eop_seen_q <= 1'b1;
      end
      if (st_q == S_REQ && sc_q == 3'h1) begin
        dreq_seen_q <= channel_request_line_in;
      end
    end
  end

  // ****************************************
  // current registers
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cur_tgt_q <= 32'h0;
      cur_req_q <= 32'h0;
      cur_cnt_q <= 32'h0;
    end else if (start | cp_chain | cp_auto) begin
      cur_tgt_q <= base_tgt_q;
      cur_req_q <= base_req_q;
      cur_cnt_q <= base_cnt_q;
    end else if (adv) begin
      cur_tgt_q <= cur_tgt_q + 32'h1;
      cur_req_q <= cur_req_q + 32'h1;
      if (cur_cnt_q != 32'h0) begin
        cur_cnt_q <= cur_cnt_q - 32'h1;
      end
    end
  end

  // ****************************************
  // chain flags
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      base_full_q <= 1'b0;
      irq_q       <= 1'b0;
    end else begin
      if (wr_msb) begin
        base_full_q <= 1'b1;
      end else if (cp_chain | (start & (pwdata_in[dcx_pkg::CTL_PROC_LSB +: 2] == dcx_pkg::PROC_CHAIN))) begin
        base_full_q <= 1'b0;
      end
      if (cp_chain | (start & (pwdata_in[dcx_pkg::CTL_PROC_LSB +: 2] == dcx_pkg::PROC_CHAIN))) begin
        irq_q <= 1'b1;
      end else if (wr_msb) begin
        irq_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stop_q <= 1'b0;
      oob_q  <= 1'b0;
    end else begin
      if (stop_ev) begin
        stop_q <= 1'b1;
      end else if (start) begin
        stop_q <= 1'b0;
      end
      if (oob_ev) begin
        oob_q <= 1'b1;
      end else if (start) begin
        oob_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // pin outputs
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hold_q     <= 1'b0;
      eop_oe_q   <= 1'b0;
      eop_n_q    <= 1'b1;
      ack_q      <= dcx_pkg::ACK_IDLE;
      acc_req_q  <= 1'b0;
      acc_tgt_q  <= 1'b0;
      acc_addr_q <= 32'h0;
    end else begin
      hold_q    <= (st_d != S_IDLE);
      eop_oe_q  <= (st_d == S_REQ) & (sc_d == 3'h1) & (cur_cnt_q == 32'h0);
      eop_n_q   <= ~((st_d == S_REQ) & (sc_d == 3'h1) & (cur_cnt_q == 32'h0));
      ack_q     <= (st_d == S_REQ) ? ctrl_q[dcx_pkg::CTL_CHAN_LSB +: 3] : dcx_pkg::ACK_IDLE;
      acc_req_q <= (st_d == S_REQ);
      acc_tgt_q <= (st_d == S_TGT);
      if (st_d == S_REQ) begin
        acc_addr_q <= cur_req_q;
      end else if (st_d == S_TGT) begin
        acc_addr_q <= cur_tgt_q;
      end
    end
  end

  assign prdata_out                 = prdata_q;
  assign pready_out                 = pready_q;
  assign pslverr_out                = pslverr_q;
  assign bus_hold_req_out           = hold_q;
  assign end_of_process_line_n_out  = eop_n_q;
  assign end_of_process_line_oe_out = eop_oe_q;
  assign encoded_channel_ack_out    = ack_q;
  assign acc_req_out                = acc_req_q;
  assign acc_tgt_out                = acc_tgt_q;
  assign acc_addr_out               = acc_addr_q;
  assign chain_reload_irq_out       = irq_q;

endmodule : dcx_chain_xfer

`default_nettype wire

// [dcx_host_model.sv]
// dcx_host_model: host side of the hold request and grant handshake
`timescale 1ns/1ps
`default_nettype none
module dcx_host_model (
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  // handshake
  input  wire logic       bus_hold_req_in,
  input  wire logic [3:0] grant_delay_in,
  output logic            bus_hold_grant_out
);
  logic [3:0] wait_q;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wait_q             <= 4'h0;
      bus_hold_grant_out <= 1'b0;
    end else if (!bus_hold_req_in) begin
      wait_q             <= 4'h0;
      bus_hold_grant_out <= 1'b0;
    end else if (wait_q == grant_delay_in) begin
      bus_hold_grant_out <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : dcx_host_model
`default_nettype wire

// [dcx_chain_xfer_chk.sv]
// dcx_chain_xfer_chk: port assertions of the chained dma channel
`timescale 1ns/1ps
`default_nettype none
module dcx_chk (
  // clock, reset and apb
  input wire logic        ref_clk_in,
  input wire logic        nrst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0]  pstrb_in,
  input wire logic        pready_out,
  // link and accesses
  input wire logic        bus_hold_req_out,
  input wire logic        bus_hold_grant_in,
  input wire logic        end_of_process_line_n_out,
  input wire logic        end_of_process_line_oe_out,
  input wire logic [2:0]  encoded_channel_ack_out,
  input wire logic        acc_req_out,
  input wire logic        acc_tgt_out,
  input wire logic        chain_reload_irq_out
);
  // ****
  // mode shadow
  // ****
  logic       wr;
  logic [8:0] ctl_q;
  logic       last_q;
  logic       aend;
  assign wr   = psel_in & penable_in & pready_out & pwrite_in;
  assign aend = ctl_q[3:2] == dcx_pkg::PROC_AUTO && last_q;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) ctl_q <= 9'h000;
    else if (wr && paddr_in == dcx_pkg::OFS_CTRL) ctl_q <= pwdata_in[8:0];
  end
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) last_q <= 1'b0;
    else if (end_of_process_line_oe_out) last_q <= 1'b1;
    else if (acc_req_out) last_q <= 1'b0;
  end
  // ****
  // properties
  // ****
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_req; acc_req_out [*2]; endsequence
  sequence s_tgt; (acc_tgt_out && !acc_req_out) [*2]; endsequence
  sequence s_end; $fell(acc_tgt_out) && !acc_req_out; endsequence
  property p_xfer; $rose(acc_req_out) |-> s_req ##1 s_tgt; endproperty
  a_xfer: assert property (p_xfer) else $error("bad transfer shape");
  property p_grant; $rose(bus_hold_grant_in) |-> !acc_req_out [*2] ##1 acc_req_out; endproperty
  a_grant: assert property (p_grant) else $error("first access not two states after grant");
  property p_rel; s_end and !ctl_q[4] && !aend |-> bus_hold_req_out ##1 !bus_hold_req_out; endproperty
  a_rel: assert property (p_rel) else $error("bus not returned one state later");
  property p_src; s_end and ctl_q[4] && !aend |-> bus_hold_req_out [*3] ##1 !bus_hold_req_out; endproperty
  a_src: assert property (p_src) else $error("source idle states wrong");
  property p_auto; s_end and aend |-> bus_hold_req_out [*7]; endproperty
  a_auto: assert property (p_auto) else $error("reload released bus early");
  property p_eop; end_of_process_line_oe_out |-> !end_of_process_line_n_out && acc_req_out && $past(acc_req_out);
  endproperty
  a_eop: assert property (p_eop) else $error("end output outside last access");
  property p_hold; acc_req_out || acc_tgt_out |-> bus_hold_req_out && bus_hold_grant_in; endproperty
  a_hold: assert property (p_hold) else $error("access without bus");
  property p_ackt; !acc_req_out |-> encoded_channel_ack_out == dcx_pkg::ACK_IDLE; endproperty
  a_ackt: assert property (p_ackt) else $error("ack not idle");
  property p_ackr; acc_req_out |-> encoded_channel_ack_out == ctl_q[7:5]; endproperty
  a_ackr: assert property (p_ackr) else $error("ack not channel");
  property p_irq; wr && paddr_in == dcx_pkg::OFS_BTGT && pstrb_in[3] && !acc_tgt_out |=> !chain_reload_irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("irq kept after top byte write");
  property p_single; s_end and ctl_q[1:0] == dcx_pkg::XFER_SINGLE |-> !acc_req_out [*4]; endproperty
  a_single: assert property (p_single) else $error("second transfer in one grant");
endmodule : dcx_chk
bind dcx_chain_xfer dcx_chk u_chk (.*);
`default_nettype wire

// [test_dma_chaining_transfer_modes.sv]
// test_dma_chaining_transfer_modes: scenarios for the chained dma channel
`timescale 1ns/1ps
`default_nettype none
module test_dma_chaining_transfer_modes;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [3:0]  pst = 4'h0;
  logic        req = 1'b0;
  logic        eop_drv = 1'b1;
  logic [3:0]  gdly = 4'h0;
  logic [31:0] prd;
  logic        prdy;
  logic        perr;
  logic        hold;
  logic        grant;
  wire         eop_n;
  logic        eop_o;
  logic        eop_oe;
  logic [2:0]  ack;
  logic        acc_r;
  logic        acc_t;
  logic        irq;
  logic [31:0] acc_a;
  logic [31:0] a_req = 32'h0;
  logic [31:0] a_tgt = 32'h0;
  logic [31:0] r;
  logic        e;
  logic        acc_p = 1'b0;
  logic        hold_p = 1'b0;
  logic        eop_p = 1'b0;
  int          n_mismatch = 0;
  int          compares = 0;
  int          n_acc = 0;
  int          n_hold = 0;
  int          n_eop = 0;
  assign eop_n = eop_oe ? eop_o : eop_drv;
  dcx_chain_xfer i_dut (.ref_clk_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(pa), .pwdata_in(pwd), .pstrb_in(pst), .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
    .bus_hold_req_out(hold), .bus_hold_grant_in(grant), .channel_request_line_in(req),
    .end_of_process_line_n_in(eop_n), .end_of_process_line_n_out(eop_o), .end_of_process_line_oe_out(eop_oe),
    .encoded_channel_ack_out(ack), .acc_req_out(acc_r), .acc_tgt_out(acc_t), .acc_addr_out(acc_a),
    .chain_reload_irq_out(irq));
  dcx_host_model i_host (.ref_clk_in(clk), .nrst_in(nrst), .bus_hold_req_in(hold), .grant_delay_in(gdly),
    .bus_hold_grant_out(grant));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ****
  // event counters, sampled mid-cycle
  // ****
  always @(negedge clk) begin
    if (acc_r === 1'b1 && acc_p !== 1'b1) n_acc++;
    if (hold === 1'b1 && hold_p !== 1'b1) n_hold++;
    if (eop_oe === 1'b1 && eop_p !== 1'b1) n_eop++;
    if (acc_r === 1'b1) a_req = acc_a;
    if (acc_t === 1'b1) a_tgt = acc_a;
    acc_p = acc_r;
    hold_p = hold;
    eop_p = eop_oe;
  end
  // ****
  // shared tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    pst <= s;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1 && n < 40) begin
      n++;
      @(posedge clk);
    end
    if (n == 40) chk(32'h1, 32'h0);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic base(input logic [31:0] cnt, input logic [31:0] tgt);
    apb(1'b1, dcx_pkg::OFS_BREQ, 32'h0000_0100, 4'hF);
    apb(1'b1, dcx_pkg::OFS_BCNT, cnt, 4'hF);
    apb(1'b1, dcx_pkg::OFS_BTGT, tgt, 4'hF);
  endtask : base
  task automatic start(input logic [1:0] x, input logic [1:0] p, input logic s);
    apb(1'b1, dcx_pkg::OFS_CTRL, 32'h0, 4'hF);
    apb(1'b1, dcx_pkg::OFS_CTRL, {23'h0, 1'b1, 3'h5, s, p, x}, 4'hF);
    n_acc = 0;
    n_hold = 0;
    n_eop = 0;
  endtask : start
  task automatic wait_acc(input int n);
    int k;
    for (k = 0; k < 2000 && n_acc < n; k++) @(posedge clk);
  endtask : wait_acc
  task automatic settle(input int n);
    int k;
    wait_acc(n);
    for (k = 0; k < 2000 && hold !== 1'b0; k++) @(posedge clk);
    repeat (20) @(posedge clk);
  endtask : settle
  // ****
  // scenarios
  // ****
  task automatic t_regs;
    apb(1'b0, dcx_pkg::OFS_CTRL, 32'h0, 4'hF);
    chk(r, dcx_pkg::CTRL_RST);
    apb(1'b0, dcx_pkg::OFS_BCNT, 32'h0, 4'hF);
    chk(r, dcx_pkg::BASE_RST);
    apb(1'b0, dcx_pkg::OFS_STAT, 32'h0, 4'hF);
    chk(r, 32'h0);
    apb(1'b0, 8'h20, 32'h0, 4'hF);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, dcx_pkg::OFS_CCNT, 32'h55, 4'hF);
    chk({31'h0, e}, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_single;
    gdly <= 4'h2;
    base(32'h2, 32'h0000_1000);
    start(dcx_pkg::XFER_SINGLE, dcx_pkg::PROC_SINGLE, 1'b0);
    req <= 1'b1;
    settle(3);
    chk(n_acc, 3);
    chk(n_hold, 3);
    chk(n_eop, 1);
    chk(a_req, 32'h0000_0102);
    chk(a_tgt, 32'h0000_1002);
    apb(1'b0, dcx_pkg::OFS_STAT, 32'h0, 4'hF);
    chk(r & 32'h15, 32'h10);
    req <= 1'b0;
    $display("test single done");
  endtask : t_single
  task automatic t_block;
    gdly <= 4'h5;
    base(32'h3, 32'h0000_1000);
    start(dcx_pkg::XFER_BLOCK, dcx_pkg::PROC_SINGLE, 1'b0);
    req <= 1'b1;
    wait_acc(1);
    req <= 1'b0;
    settle(4);
    chk(n_acc, 4);
    chk(n_hold, 1);
    $display("test block done");
  endtask : t_block
  task automatic t_demand;
    gdly <= 4'h0;
    base(32'h4, 32'h0000_1000);
    start(dcx_pkg::XFER_DEMAND, dcx_pkg::PROC_SINGLE, 1'b0);
    req <= 1'b1;
    wait_acc(2);
    req <= 1'b0;
    settle(2);
    chk(n_acc, 2);
    apb(1'b0, dcx_pkg::OFS_CCNT, 32'h0, 4'hF);
    chk(r, 32'h2);
    req <= 1'b1;
    wait_acc(5);
    req <= 1'b0;
    settle(5);
    chk(n_acc, 5);
    chk(n_hold, 2);
    chk(a_req, 32'h0000_0104);
    $display("test demand done");
  endtask : t_demand
  task automatic t_chain;
    base(32'h1, 32'h0000_1000);
    start(dcx_pkg::XFER_BLOCK, dcx_pkg::PROC_CHAIN, 1'b0);
    apb(1'b0, dcx_pkg::OFS_STAT, 32'h0, 4'hF);
    chk(r & 32'hE, 32'h8);
    apb(1'b1, dcx_pkg::OFS_BTGT, 32'h2000_0000, 4'h8);
    apb(1'b0, dcx_pkg::OFS_STAT, 32'h0, 4'hF);
    chk(r & 32'hE, 32'h2);
    req <= 1'b1;
    wait_acc(3);
    eop_drv <= 1'b0;
    repeat (3) @(posedge clk);
    eop_drv <= 1'b1;
    settle(3);
    chk(n_acc, 3);
    chk(n_hold, 2);
    chk(a_tgt, 32'h2000_1000);
    chk(a_req, 32'h0000_0100);
    apb(1'b0, dcx_pkg::OFS_STAT, 32'h0, 4'hF);
    chk(r & 32'h1E, 32'h1C);
    req <= 1'b0;
    $display("test chain done");
  endtask : t_chain
  task automatic t_auto;
    base(32'h1, 32'h0000_3000);
    start(dcx_pkg::XFER_DEMAND, dcx_pkg::PROC_AUTO, 1'b1);
    req <= 1'b1;
    wait_acc(1);
    req <= 1'b0;
    settle(1);
    req <= 1'b1;
    wait_acc(2);
    req <= 1'b0;
    settle(2);
    chk(n_hold, 2);
    apb(1'b0, dcx_pkg::OFS_CCNT, 32'h0, 4'hF);
    chk(r, 32'h1);
    $display("test auto done");
  endtask : t_auto
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_single();
    t_block();
    t_demand();
    t_chain();
    t_auto();
    conclude();
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
endmodule : test_dma_chaining_transfer_modes
`default_nettype wire
